// ---- rtl/prc_pkg.sv ----
// Constants and types for the receive overhead control block
package prc_pkg;
    // Register data width
    localparam int REG_W = 8;
    // Register offsets on the register port
    localparam logic [7:0] ADDR_CTRL0 = 8'hB0;
    localparam logic [7:0] ADDR_CTRL1 = 8'hB1;
    localparam logic [7:0] ADDR_BUFF1 = 8'hB2;
    localparam logic [7:0] ADDR_ECNT = 8'h83;
    localparam logic [7:0] ADDR_CRCCNT = 8'h84;
    localparam logic [7:0] ADDR_CODE = 8'h85;
    localparam logic [7:0] ADDR_MON0 = 8'h86;
    localparam logic [7:0] ADDR_MON2 = 8'h87;
    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] BUFF1_RST = 8'h00;
    // Fields of receive_primary_control_1
    localparam int C1_ENABLE = 0;
    localparam int C1_BYPASS = 1;
    localparam int C1_CRC_LO = 2;
    localparam int C1_ALARM = 5;
    localparam int C1_CLR_E = 6;
    localparam int C1_CLR_CRC = 7;
    // Source-select fields of receive_primary_control_0
    localparam int C0_SA4 = 0;
    localparam int C0_SA7 = 4;
    localparam int C0_SA8 = 5;
    // Fields of receive_spare_bit_buffer_1
    localparam int B1_SA4 = 0;
    localparam int B1_SA7 = 1;
    localparam int B1_SA8 = 2;
    localparam int B1_MASK_A = 4;
    localparam int B1_MASK_SA5 = 5;
    localparam int B1_MASK_SA6 = 6;
    // Packing of the word crossing into the link domain
    localparam int CFG_W = 24;
    localparam int CFG_CTRL1 = 8;
    localparam int CFG_BUFF1 = 16;
    // Packing of the status word crossing back
    localparam int STAT_W = 29;
    localparam int MON0_SYNC = 7;
    // Check-bit source codes and the check polynomial
    localparam logic [1:0] CRC_PASS = 2'h0;
    localparam logic [1:0] CRC_ONES = 2'h1;
    localparam logic [1:0] CRC_CALC = 2'h2;
    localparam logic [3:0] CRC_POLY = 4'h3;
    // Frame geometry
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] SLOT_LAST = 5'h1F;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [2:0] SMF_LAST = 3'h7;
    localparam logic [3:0] FRAME_E1 = 4'hD;
    localparam logic [3:0] FRAME_E2 = 4'hF;
    // Spare-bit positions in slot 0 of odd frames
    localparam logic [2:0] POS_A = 3'h2;
    localparam logic [2:0] POS_SA4 = 3'h3;
    localparam logic [2:0] POS_SA5 = 3'h4;
    localparam logic [2:0] POS_SA6 = 3'h5;
    localparam logic [2:0] POS_SA7 = 3'h6;
    localparam logic [2:0] POS_SA8 = 3'h7;
    // Multiframe alignment word, ends in frame 11
    localparam logic [5:0] MFAS_PATTERN = 6'h0B;
    localparam logic [3:0] FRAME_AFTER_MFAS = 4'hC;
    // Identical multiframes beyond the first before a code counts
    localparam logic [2:0] SAME_NEED = 3'h7;
    // Alarm fill bit value
    localparam logic ALARM_BIT = 1'b1;
    // Multiframe synchronization states
    typedef enum logic {SYNC_HUNT, SYNC_LOCKED} prc_sync_e;
endpackage : prc_pkg

// ---- rtl/prc_rx_overhead_ctrl.sv ----
// Receive primary-rate overhead control toward the PCM link
// Notes on behaviour
// R1 - Enable bit 0 passes data through and stops sync and counting, 1 runs
// R2 - Bypass 0: hunt for sync, marker marks frames
// R3 - Bypass 1: marker input is the multiframe boundary
// R4 - Check bits: pass, all ones, calculated, illegal
// R5 - Alarm fill replaces all slots except slot 0
// R6 - Control 1 writes apply at next multiframe
// R7 - Buffer bits used only where source-select set
// R8 - Buffer writes apply at next multiframe
// R9 - Buffer bits 0-2 drive Sa4, Sa7, Sa8
// R10 - Code reported after 8 identical multiframes
// R11 - Mask bits exclude A, Sa5, Sa6 fields
// R12 - E-bit counter counts low E-bits, wraps
// R13 - CRC counter counts check mismatches
// R14 - E-counter clear bit holds counter at zero
// R15 - CRC-counter clear bit holds counter at zero
`timescale 1ns/1ps
`default_nettype none
module prc_rx_overhead_ctrl (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [prc_pkg::REG_W-1:0] regWrData,
    input wire logic regWrite,
    output logic [prc_pkg::REG_W-1:0] regRdData,
    // Link side on the PCM clock
    input wire logic pcmClk,
    input wire logic rxBit,
    input wire logic receiveMultiframeSyncIn,
    output logic pcmDataOut,
    output logic pcmMfSyncOut
);
    import prc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Core domain: register file
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] buff1;
    logic cfgLoad;
    logic [STAT_W-1:0] statusCore;
    logic [7:0] rdMux;

    // Address decode
    wire wrCtrl0 = regWrite & (regAddr == ADDR_CTRL0);
    wire wrCtrl1 = regWrite & (regAddr == ADDR_CTRL1);
    wire wrBuff1 = regWrite & (regAddr == ADDR_BUFF1);
    wire [7:0] stE = statusCore[7:0];
    wire [7:0] stCrc = statusCore[15:8];
    wire [7:0] stCode = statusCore[23:16];
    wire stLocked = statusCore[24];
    wire [3:0] stOffset = statusCore[28:25];

    // Read selection; unmapped offsets read zero
    assign rdMux = (regAddr == ADDR_CTRL0) ? ctrl0 :
                   (regAddr == ADDR_CTRL1) ? ctrl1 :
                   (regAddr == ADDR_BUFF1) ? buff1 :
                   (regAddr == ADDR_ECNT) ? stE :
                   (regAddr == ADDR_CRCCNT) ? stCrc :
                   (regAddr == ADDR_CODE) ? stCode :
                   (regAddr == ADDR_MON0) ? {stLocked, 7'h00} :
                   (regAddr == ADDR_MON2) ? {4'h0, stOffset} : 8'h00;

    // Writable registers; the crossing loads one cycle later
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl0 <= CTRL0_RST;
            ctrl1 <= CTRL1_RST;
            buff1 <= BUFF1_RST;
            cfgLoad <= 1'b0;
            regRdData <= 8'h00;
        end else begin
            if (wrCtrl0) ctrl0 <= regWrData;
            if (wrCtrl1) ctrl1 <= regWrData;
            if (wrBuff1) buff1 <= regWrData;
            cfgLoad <= wrCtrl0 | wrCtrl1 | wrBuff1;
            regRdData <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link domain reset and crossings
    logic pcmRstMeta;
    logic pcmReset;
    logic [CFG_W-1:0] cfgWord;
    logic cfgNew;
    logic [STAT_W-1:0] statusWord;
    logic statusLoad;

    // Reset brought into the link clock
    always_ff @(posedge pcmClk) begin
        pcmRstMeta <= reset;
        pcmReset <= pcmRstMeta;
    end

    // Control words into the link domain
    prc_word_sync #(.WIDTH(CFG_W)) cfgSync (
        .srcClk(core_clk),
        .srcReset(reset),
        .srcLoad(cfgLoad),
        .srcData({buff1, ctrl1, ctrl0}),
        .dstClk(pcmClk),
        .dstReset(pcmReset),
        .dstData(cfgWord),
        .dstNew(cfgNew)
    );

    // Status snapshot back once per multiframe
    prc_word_sync #(.WIDTH(STAT_W)) statSync (
        .srcClk(pcmClk),
        .srcReset(pcmReset),
        .srcLoad(statusLoad),
        .srcData(statusWord),
        .dstClk(core_clk),
        .dstReset(reset),
        .dstData(statusCore),
        .dstNew()
    );

    ////////////////////////////////////////////////////////////////////
    // Link domain: values applied at multiframe start
    logic pending;
    logic [7:0] ctrl0Act;
    logic [7:0] ctrl1Act;
    logic [7:0] buff1Act;
    logic [2:0] bitCnt;
    logic [4:0] slotCnt;
    logic [3:0] frameCnt;
    prc_sync_e syncState;
    logic [3:0] syncOffset;
    logic [11:0] firstBits;

    // Applied controls
    wire enable = ctrl1Act[C1_ENABLE];
    wire bypass = ctrl1Act[C1_BYPASS];
    wire [1:0] crcMode = ctrl1Act[C1_CRC_LO +: 2];
    wire alarm = ctrl1Act[C1_ALARM];
    wire clrE = ctrl1Act[C1_CLR_E];
    wire clrCrc = ctrl1Act[C1_CLR_CRC];

    // Current bit position; the marker restarts the frame
    wire markerHit = enable & receiveMultiframeSyncIn; // R2
    wire [2:0] curBit = markerHit ? 3'h0 : bitCnt;
    wire [4:0] curSlot = markerHit ? 5'h00 : slotCnt;
    wire [3:0] curFrame = (markerHit & bypass) ? 4'h0 : frameCnt; // R3
    wire endBit = curBit == BIT_LAST;
    wire endFrame = endBit & (curSlot == SLOT_LAST);
    wire mfStart = (curBit == 3'h0) & (curSlot == 5'h00) &
                   (curFrame == 4'h0);
    wire mfEnd = endFrame & (curFrame == FRAME_LAST);
    wire smfEnd = endFrame & (curFrame[2:0] == SMF_LAST);
    wire applyNow = pending & mfStart;
    wire ts0 = curSlot == 5'h00;
    wire oddFrame = curFrame[0];
    wire hunting = syncState == SYNC_HUNT;
    wire aligned = enable & (bypass | !hunting);

    // Frame counter loads from the alignment word while hunting
    wire mfasOk = {firstBits[10], firstBits[8], firstBits[6],
                   firstBits[4], firstBits[2], firstBits[0]} ==
                  MFAS_PATTERN;
    wire mfasLock = enable & !bypass & hunting & endFrame & mfasOk; // R2
    wire [2:0] next_bitCnt = curBit + 3'h1;
    wire [4:0] next_slotCnt = endBit ? curSlot + 5'h01 : curSlot;
    wire [3:0] next_frameCnt = mfasLock ? FRAME_AFTER_MFAS :
                               endFrame ? curFrame + 4'h1 : curFrame;

    // Pending set wins over the apply in the same cycle
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            pending <= 1'b0;
            ctrl0Act <= CTRL0_RST;
            ctrl1Act <= CTRL1_RST;
            buff1Act <= BUFF1_RST;
        end else begin
            pending <= cfgNew | (pending & !mfStart);
            if (applyNow) begin
                ctrl0Act <= cfgWord[7:0];
                ctrl1Act <= cfgWord[CFG_CTRL1 +: 8]; // R6
                buff1Act <= cfgWord[CFG_BUFF1 +: 8]; // R8
            end
        end
    end

    // Position counters run free so disabled links stay timed
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            bitCnt <= 3'h0;
            slotCnt <= 5'h00;
            frameCnt <= 4'h0;
            firstBits <= 12'h000;
        end else begin
            bitCnt <= next_bitCnt;
            slotCnt <= next_slotCnt;
            frameCnt <= next_frameCnt;
            if (ts0 && curBit == 3'h0) firstBits <= {firstBits[10:0], rxBit};
        end
    end

    // Synchronization machine; a write with bypass 0 forces hunt
    always_ff @(posedge pcmClk) begin
        if (pcmReset || !enable) begin
            syncState <= SYNC_HUNT; // R1
            syncOffset <= 4'h0;
        end else if (applyNow && !cfgWord[CFG_CTRL1 + C1_BYPASS]) begin
            syncState <= SYNC_HUNT; // R2
        end else begin
            case (syncState)
                SYNC_HUNT: begin
                    if (mfasLock) begin
                        syncState <= SYNC_LOCKED;
                        syncOffset <= curFrame;
                    end
                end
                SYNC_LOCKED: syncState <= SYNC_LOCKED;
                default: syncState <= SYNC_HUNT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Check-bit calculation over each submultiframe
    logic [3:0] crcAcc;
    logic [3:0] prevCalc;
    logic crcMiss;
    logic [7:0] eCnt;
    logic [7:0] crcCnt;

    wire cBitRaw = ts0 & (curBit == 3'h0) & !oddFrame;
    wire cBitPos = cBitRaw & aligned;
    wire cBitCalc = prevCalc[~curFrame[2:1]];
    wire crcIn = cBitRaw ? 1'b0 : rxBit;
    wire crcFb = crcIn ^ crcAcc[3];
    wire [3:0] next_crcAcc = {crcAcc[2:0], 1'b0} ^
                             (crcFb ? CRC_POLY : 4'h0);
    wire eBitPos = ts0 & (curBit == 3'h0) &
                   ((curFrame == FRAME_E1) | (curFrame == FRAME_E2));

    // Remainder is compared in the following submultiframe
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            crcAcc <= 4'h0;
            prevCalc <= 4'h0;
            crcMiss <= 1'b0;
        end else if (smfEnd) begin
            crcAcc <= 4'h0;
            prevCalc <= next_crcAcc;
            crcMiss <= 1'b0;
        end else begin
            crcAcc <= next_crcAcc;
            if (cBitRaw && rxBit != cBitCalc) crcMiss <= 1'b1;
        end
    end

    // Error counters wrap at 255; a clear bit holds them at zero
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            eCnt <= 8'h00;
            crcCnt <= 8'h00;
        end else begin
            if (clrE) eCnt <= 8'h00; // R14
            else if (aligned && eBitPos && !rxBit) eCnt <= eCnt + 8'h01; // R12
            if (clrCrc) crcCnt <= 8'h00; // R15
            else if (aligned && smfEnd && crcMiss) crcCnt <= crcCnt + 8'h01; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // In-band code constancy check
    logic [7:0] codeNow;
    logic [7:0] codePrev;
    logic [7:0] code;
    logic [2:0] sameCnt;

    wire spareSlot = aligned & ts0 & oddFrame;
    wire [7:0] maskVec = {{4{buff1Act[B1_MASK_SA6]}}, 2'h0,
                          buff1Act[B1_MASK_SA5], buff1Act[B1_MASK_A]}; // R11
    wire codeSame = ((codeNow ^ codePrev) & ~maskVec) == 8'h00; // R11
    wire [2:0] sameNext = !codeSame ? 3'h0 :
                          (sameCnt == SAME_NEED) ? SAME_NEED :
                          sameCnt + 3'h1;

    // Sa6 sits in frames 1, 3, 5, 7; A and Sa5 taken in frame 1
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            codeNow <= 8'h00;
            codePrev <= 8'h00;
            code <= 8'h00;
            sameCnt <= 3'h0;
        end else begin
            if (spareSlot && curFrame == 4'h1 && curBit == POS_A) codeNow[0] <= rxBit;
            if (spareSlot && curFrame == 4'h1 && curBit == POS_SA5) codeNow[1] <= rxBit;
            if (spareSlot && !curFrame[3] && curBit == POS_SA6)
                codeNow[{1'b1, curFrame[2:1]}] <= rxBit;
            if (aligned && mfEnd) begin
                codePrev <= codeNow;
                sameCnt <= sameNext;
                if (sameNext == SAME_NEED) code <= codeNow; // R10
            end
        end
    end

    // Status snapshot taken the cycle after the multiframe ends
    assign statusWord = {syncOffset, !hunting, code, crcCnt, eCnt};
    always_ff @(posedge pcmClk) begin
        if (pcmReset) statusLoad <= 1'b0;
        else statusLoad <= mfEnd;
    end

    ////////////////////////////////////////////////////////////////////
    // Output bit toward the PCM framer
    logic crcOut;
    logic outBit;

    always_comb begin
        case (crcMode)
            CRC_ONES: crcOut = 1'b1; // R4
            CRC_CALC: crcOut = cBitCalc; // R4
            default: crcOut = rxBit; // R4
        endcase
    end

    // Buffered spare bits only where selected
    wire sa4Sel = spareSlot & (curBit == POS_SA4) & ctrl0Act[C0_SA4]; // R7
    wire sa7Sel = spareSlot & (curBit == POS_SA7) & ctrl0Act[C0_SA7]; // R7
    wire sa8Sel = spareSlot & (curBit == POS_SA8) & ctrl0Act[C0_SA8]; // R7
    assign outBit = !enable ? rxBit : // R1
                    (alarm && !ts0) ? ALARM_BIT : // R5
                    cBitPos ? crcOut :
                    sa4Sel ? buff1Act[B1_SA4] : // R9
                    sa7Sel ? buff1Act[B1_SA7] : // R9
                    sa8Sel ? buff1Act[B1_SA8] : rxBit; // R9

    // One bit of delay through the block
    always_ff @(posedge pcmClk) begin
        if (pcmReset) begin
            pcmDataOut <= 1'b0;
            pcmMfSyncOut <= 1'b0;
        end else begin
            pcmDataOut <= outBit;
            pcmMfSyncOut <= mfStart & aligned;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_cfg_applied;
        pending ##0 mfStart;
    endsequence
    sequence s_code_ok;
        aligned && mfEnd && sameNext == SAME_NEED;
    endsequence

    a_disable_pass: assert property (@(posedge pcmClk) disable iff (pcmReset) // R1
        !enable |=> pcmDataOut == $past(rxBit))
        else $error("disabled path not transparent");
    a_hunt_forced: assert property (@(posedge pcmClk) disable iff (pcmReset) // R2
        applyNow && !cfgWord[CFG_CTRL1 + C1_BYPASS] |=> hunting)
        else $error("hunt not forced");
    a_bypass_marker: assert property (@(posedge pcmClk) disable iff (pcmReset) // R3
        enable && bypass && receiveMultiframeSyncIn |=> pcmMfSyncOut)
        else $error("marker not taken as boundary");
    a_crc_ones: assert property (@(posedge pcmClk) disable iff (pcmReset) // R4
        cBitPos && crcMode == CRC_ONES |=> pcmDataOut)
        else $error("check bit not one");
    a_alarm_fill: assert property (@(posedge pcmClk) disable iff (pcmReset) // R5
        enable && alarm && !ts0 |=> pcmDataOut == ALARM_BIT)
        else $error("alarm fill missing");
    a_ctrl_apply: assert property (@(posedge pcmClk) disable iff (pcmReset) // R6
        ctrl1Act != $past(ctrl1Act) |-> $past(pending && mfStart))
        else $error("control changed mid multiframe");
    a_sa4_ignored: assert property (@(posedge pcmClk) disable iff (pcmReset) // R7
        spareSlot && curBit == POS_SA4 && !ctrl0Act[C0_SA4]
        |=> pcmDataOut == $past(rxBit))
        else $error("unselected buffer bit used");
    a_buff_apply: assert property (@(posedge pcmClk) disable iff (pcmReset) // R8
        s_cfg_applied |=> buff1Act == $past(cfgWord[CFG_BUFF1 +: 8]))
        else $error("buffer not applied at boundary");
    a_sa8_insert: assert property (@(posedge pcmClk) disable iff (pcmReset) // R9
        sa8Sel |=> pcmDataOut == $past(buff1Act[B1_SA8]))
        else $error("Sa8 not inserted");
    a_code_update: assert property (@(posedge pcmClk) disable iff (pcmReset) // R10
        code != $past(code) |-> $past(aligned && mfEnd && sameNext == SAME_NEED))
        else $error("code updated too early");
    a_code_taken: assert property (@(posedge pcmClk) disable iff (pcmReset) // R11
        s_code_ok |=> code == $past(codeNow))
        else $error("code not updated");
    a_ecnt_step: assert property (@(posedge pcmClk) disable iff (pcmReset) // R12
        aligned && eBitPos && !rxBit && !clrE |=> eCnt == $past(eCnt) + 8'h01)
        else $error("E-bit counter missed");
    a_crc_step: assert property (@(posedge pcmClk) disable iff (pcmReset) // R13
        aligned && smfEnd && crcMiss && !clrCrc
        |=> crcCnt == $past(crcCnt) + 8'h01)
        else $error("CRC counter missed");
    a_ecnt_clear: assert property (@(posedge pcmClk) disable iff (pcmReset) // R14
        clrE |=> eCnt == 8'h00)
        else $error("E-bit counter not cleared");
    a_crc_clear: assert property (@(posedge pcmClk) disable iff (pcmReset) // R15
        clrCrc [*2] |-> crcCnt == 8'h00)
        else $error("CRC counter not cleared");
endmodule : prc_rx_overhead_ctrl
`default_nettype wire

// ---- rtl/prc_word_sync.sv ----
// Toggle handshake that carries a held word between two clocks
`timescale 1ns/1ps
`default_nettype none
module prc_word_sync #(
    parameter int WIDTH = 8
) (
    // Source side
    input wire logic srcClk,
    input wire logic srcReset,
    input wire logic srcLoad,
    input wire logic [WIDTH-1:0] srcData,
    // Destination side
    input wire logic dstClk,
    input wire logic dstReset,
    output logic [WIDTH-1:0] dstData,
    output logic dstNew
);
    logic [WIDTH-1:0] holdData;
    logic srcToggle;
    logic dstMeta;
    logic dstSync;
    logic dstLast;
    wire dstSeen = dstSync ^ dstLast;

    // Word is held until the next load; loads must be spaced
    always_ff @(posedge srcClk) begin
        if (srcReset) begin
            holdData <= '0;
            srcToggle <= 1'b0;
        end else if (srcLoad) begin
            holdData <= srcData;
            srcToggle <= ~srcToggle;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Only the toggle is synchronised; the word is stable by then
    always_ff @(posedge dstClk) begin
        if (dstReset) begin
            dstMeta <= 1'b0;
            dstSync <= 1'b0;
            dstLast <= 1'b0;
            dstNew <= 1'b0;
            dstData <= '0;
        end else begin
            dstMeta <= srcToggle;
            dstSync <= dstMeta;
            dstLast <= dstSync;
            dstNew <= dstSeen;
            if (dstSeen) begin
                dstData <= holdData;
            end
        end
    end
endmodule : prc_word_sync
`default_nettype wire

// ---- test/prc_pcm_framer_model.sv ----
// Far-end framer model: multiframe marker source and bit position
`timescale 1ns/1ps
`default_nettype none
module prc_pcm_framer_model (
    // Link clock
    input wire logic pcmClk,
    // From the block
    input wire logic pcmDataOut,
    input wire logic pcmMfSyncOut,
    // Toward the block
    output logic marker,
    output logic [11:0] bitPos
);
    ////////////////////////////////////////////////////////////////////////
    // Start one bit short so the first count lands on the boundary
    logic [11:0] pos = 12'hFFF;
    logic mark = 1'b0;
    assign bitPos = pos;
    assign marker = mark;
    // Free count of 4096 bits, marker pulsed with bit 0 of each multiframe
    always @(negedge pcmClk) begin
        pos <= pos + 12'h001;
        mark <= (pos == 12'hFFF);
    end
endmodule : prc_pcm_framer_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the receive overhead control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prc_pkg::*;
    // Row 0 sits rightmost; row 1 runs the hunt with nothing inserted
    localparam logic [5:0][7:0] C1T = {8'hCB, 8'h0F, 8'h07, 8'h23, 8'h01,
        8'h20};
    localparam logic [5:0][7:0] C0T = {8'h30, 8'h01, 8'h31, 8'h31, 8'h00,
        8'h31};
    logic core_clk = 1'b0;
    logic pcmClk = 1'b0;
    logic reset = 1'b1;
    logic rxBit = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] c0 = 8'h00;
    logic [7:0] c1 = 8'h00;
    logic [7:0] b1 = 8'h00;
    logic [31:0] seed = 32'h43;
    logic [11:0] bitPos;
    logic marker;
    logic pcmDataOut;
    logic pcmMfSyncOut;
    wire [7:0] regRdData;
    int miscompares = 0;
    int samples_checked = 0;
    bit chkOn = 1'b0;
    wire mfExp = c1[C1_ENABLE] && bitPos == 12'h000;
    ////////////////////////////////////////////////////////////////////////
    // Clocks; 50 ns against 32 ns keeps the phases drifting
    always #25 core_clk = ~core_clk;
    always #16 pcmClk = ~pcmClk;
    prc_rx_overhead_ctrl dut (.core_clk(core_clk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRdData(regRdData), .pcmClk(pcmClk), .rxBit(rxBit),
        .receiveMultiframeSyncIn(marker), .pcmDataOut(pcmDataOut),
        .pcmMfSyncOut(pcmMfSyncOut));
    prc_pcm_framer_model partner (.pcmClk(pcmClk), .pcmDataOut(pcmDataOut),
        .pcmMfSyncOut(pcmMfSyncOut), .marker(marker), .bitPos(bitPos));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Reference output bit for a taken bit at a given multiframe position
    function automatic logic expBit(input logic d, input logic [11:0] p);
        if (!c1[C1_ENABLE]) return d;
        if (p[7:3] != 5'h00) return c1[C1_ALARM] ? ALARM_BIT : d;
        if (!p[8]) return (p[2:0] == 3'h0 &&
            c1[C1_CRC_LO +: 2] == CRC_ONES) ? 1'b1 : d;
        if (p[2:0] == POS_SA4 && c0[C0_SA4]) return b1[B1_SA4];
        if (p[2:0] == POS_SA7 && c0[C0_SA7]) return b1[B1_SA7];
        if (p[2:0] == POS_SA8 && c0[C0_SA8]) return b1[B1_SA8];
        return d;
    endfunction : expBit
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk) regAddr = a;
        @(negedge core_clk) chk(regRdData, exp);
    endtask : rd8
    // Writes are spaced well apart so no crossing carries a mixed word
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge core_clk) regWrite = 1'b0;
        repeat (10) @(negedge core_clk);
        rd8(a, d);
    endtask : wr
    task automatic print_verdict;
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    // Link side: compare the bit taken last edge, then drive a new one;
    // calculated check bits are not modelled, so those slots are skipped
    always @(negedge pcmClk) begin
        if (chkOn && !(c1[C1_CRC_LO +: 2] == CRC_CALC &&
            bitPos[8:0] == 9'h000)) begin
            chk({7'h00, pcmDataOut}, {7'h00, expBit(rxBit, bitPos)});
        end
        // While hunting the lock point depends on the data, so no pulse check
        if (chkOn && (c1[C1_BYPASS] || !c1[C1_ENABLE])) begin
            chk({7'h00, pcmMfSyncOut}, {7'h00, mfExp});
        end
        seed <= xs(seed);
        rxBit <= seed[0];
    end
    // Hang guard, well beyond about twenty multiframes of traffic
    initial begin
        #5000000;
        miscompares++;
        print_verdict;
    end
    // Main sequence: reset values, then one configuration per table row
    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        repeat (4) @(posedge pcmClk);
        rd8(ADDR_CTRL0, CTRL0_RST);
        rd8(ADDR_CTRL1, CTRL1_RST);
        rd8(ADDR_BUFF1, BUFF1_RST);
        rd8(8'h99, 8'h00);
        for (int i = 0; i < 6; i++) begin
            // Copies first: the seed moves on every link bit
            c0 = C0T[i];
            // All compare masks set so the code detector gets to report
            b1 = {4'h7, 1'b0, seed[2:0]};
            c1 = C1T[i];
            wr(ADDR_CTRL0, c0);
            wr(ADDR_BUFF1, b1);
            wr(ADDR_CTRL1, c1);
            repeat (2) @(posedge marker);
            chkOn = 1'b1;
            @(posedge marker);
            chkOn = 0;
            if (C1T[i][C1_CLR_E]) begin
                rd8(ADDR_ECNT, 8'h00);
                rd8(ADDR_CRCCNT, 8'h00);
            end
        end
        // Mid-multiframe write must wait for the next boundary
        @(posedge marker);
        chkOn = 1'b1;
        wr(ADDR_CTRL1, 8'h00);
        @(posedge marker);
        // Boundary bit still leaves under the old setting
        repeat (2) @(posedge pcmClk);
        c1 = 8'h00;
        @(posedge marker);
        chkOn = 1'b0;
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
